// ===== instr_timing_pkg.sv
// Purpose: shared constants and types for the instruction cycle sequencer
// Assumes: 24-bit program words, opcode in the top eight bits
// Notes:   opcode codes and field positions are local to this core
package instr_timing_pkg;

  localparam int WORD_W = 24;
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 16;

  // opcode classes; 8'h00 is the no-operation
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_DWORD    = 8'h01;
  localparam logic [7:0] OPC_MOVD     = 8'h02;
  localparam logic [7:0] OPC_COND     = 8'h03;
  localparam logic [7:0] OPC_PCMOD    = 8'h04;
  localparam logic [7:0] OPC_BRANCH   = 8'h05;
  localparam logic [7:0] OPC_IND_JUMP = 8'h06;
  localparam logic [7:0] OPC_TABLE    = 8'h07;
  localparam logic [7:0] OPC_RETURN   = 8'h08;
  localparam logic [7:0] OPC_INT_RET  = 8'h09;
  localparam logic [7:0] OPC_SKIP     = 8'h0a;

  // operand fields of the first word
  localparam int ACC_SEL_BIT = 15;
  localparam int DEST_HI     = 14;
  localparam int DEST_LO     = 13;

  // write-back destination modes
  localparam logic [1:0] DEST_NONE    = 2'h0;
  localparam logic [1:0] DEST_DIRECT  = 2'h1;
  localparam logic [1:0] DEST_POSTINC = 2'h2;
  localparam logic [3:0] DEST_REG     = 4'hd;
  localparam logic [1:0] DEST_STEP    = 2'h2;

  // bubbles added after the first cycle
  localparam logic [1:0] EXTRA_NONE  = 2'h0;
  localparam logic [1:0] EXTRA_PCMOD = 2'h1;
  localparam logic [1:0] EXTRA_FLOW2 = 2'h1;
  localparam logic [1:0] EXTRA_FLOW3 = 2'h2;
  localparam logic [1:0] EXTRA_COND  = 2'h1;
  localparam logic [1:0] EXTRA_SKIP2 = 2'h1;
  localparam logic [1:0] BUBBLE_LAST = 2'h1;

  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_ONE  = 2'h1;
  localparam logic [1:0] CYC_TWO  = 2'h2;

  localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

  typedef enum logic [2:0] {
    cls_single, cls_double, cls_cond, cls_pcmod, cls_flow2, cls_flow3, cls_skip
  } instr_class_t;

  typedef struct packed {
    logic                  valid;
    logic [2*WORD_W-1:0]   bits;
    logic                  acc_b;
    logic [1:0]            dest_mode;
    logic [3:0]            dest_reg;
    logic [1:0]            dest_step;
  } issue_t;

  typedef struct packed {
    logic       done;
    logic [1:0] cycles;
  } retire_t;

endpackage : instr_timing_pkg

// ===== instr_class_decode.sv
// Purpose: maps an opcode to its timing class and fixed bubble count
// Assumes: opcode taken from the top eight bits of a program word
// Notes:   purely combinational; unknown opcodes run as one-cycle ops
`timescale 1ns/10ps
module instr_class_decode (
  input  wire logic [7:0]                   opcode_in,
  output instr_timing_pkg::instr_class_t    class_out,
  output logic      [1:0]                   extra_out
);

  always_comb begin
    class_out = instr_timing_pkg::cls_single;
    extra_out = instr_timing_pkg::EXTRA_NONE;
    case (opcode_in)
      instr_timing_pkg::OPC_DWORD,
      instr_timing_pkg::OPC_MOVD: begin
        class_out = instr_timing_pkg::cls_double;
      end
      instr_timing_pkg::OPC_COND: begin
        class_out = instr_timing_pkg::cls_cond;
      end
      instr_timing_pkg::OPC_PCMOD: begin
        class_out = instr_timing_pkg::cls_pcmod;
        extra_out = instr_timing_pkg::EXTRA_PCMOD;
      end
      instr_timing_pkg::OPC_BRANCH,
      instr_timing_pkg::OPC_IND_JUMP: begin
        class_out = instr_timing_pkg::cls_flow2;
        extra_out = instr_timing_pkg::EXTRA_FLOW2;
      end
      instr_timing_pkg::OPC_TABLE,
      instr_timing_pkg::OPC_RETURN,
      instr_timing_pkg::OPC_INT_RET: begin
        class_out = instr_timing_pkg::cls_flow3;
        extra_out = instr_timing_pkg::EXTRA_FLOW3;
      end
      instr_timing_pkg::OPC_SKIP: begin
        class_out = instr_timing_pkg::cls_skip;
      end
      default: begin
        class_out = instr_timing_pkg::cls_single;
      end
    endcase
  end

endmodule : instr_class_decode

// ===== instr_cycle_timing.sv
// Purpose: sequences program words into issued instructions and bubbles
// Assumes: one program word offered per cycle, cond_true_in valid with it
// Notes:   every discarded word becomes a bubble with no architectural effect
//
// Notes on behaviour
// - double-word instructions carry 48 bits over two consecutive words
// - second word has zero top byte; executed alone it is a no-operation
// - every double-word instruction completes in exactly two cycles
// - single-word instructions take one cycle unless condition true or pc changed
// - true condition or pc change: two cycles, extra one a no-operation
// - branch, indirect call/jump, table access, returns take two or three cycles
// - taken skip: two cycles over a one-word, three over a two-word instruction
// - double-word move completes in two cycles
// - accumulator operand is A or B, chosen by the instruction
// - write-back goes to register 13, direct or indirect with post-increment 2
`timescale 1ns/10ps
module instr_cycle_timing (
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  input  wire logic                 ce_in,
  input  wire logic                 word_valid_in,
  input  wire logic [23:0]          word_in,
  input  wire logic                 cond_true_in,
  output instr_timing_pkg::issue_t  issue_out,
  output logic                      bubble_out,
  output instr_timing_pkg::retire_t retire_out
);

  typedef enum logic [1:0] {st_fetch, st_second, st_bubble, st_skip} seq_state_t;

  seq_state_t                     state;
  logic [23:0]                    first_word;
  logic [1:0]                     bubbles_left;
  logic [1:0]                     cyc;
  instr_timing_pkg::instr_class_t word_class;
  logic [1:0]                     fixed_extra;
  logic [1:0]                     next_extra;
  logic                           take;
  logic                           skip_now;
  logic                           issue_now;
  logic [23:0]                    head_word;
  logic [1:0]                     head_dest;

  instr_class_decode u_decode (
    .opcode_in (word_in[instr_timing_pkg::OPC_HI:instr_timing_pkg::OPC_LO]),
    .class_out (word_class),
    .extra_out (fixed_extra)
  );

  assign take     = ce_in & word_valid_in;
  assign skip_now = (word_class == instr_timing_pkg::cls_skip) & cond_true_in;
  // only a lone word in its first cycle, or the second word of a pair, issues
  assign issue_now = word_valid_in
                     & ((state == st_fetch && word_class != instr_timing_pkg::cls_double)
                        || state == st_second);

  // conditional class only pays its bubble when the test comes out true
  always_comb begin
    next_extra = fixed_extra;
    if (word_class == instr_timing_pkg::cls_cond && cond_true_in) begin
      next_extra = instr_timing_pkg::EXTRA_COND;
    end
  end

  // sequencer state; a stalled or frozen cycle leaves it alone
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state <= st_fetch;
    end else if (take) begin
      case (state)
        st_fetch: begin
          if (word_class == instr_timing_pkg::cls_double) begin
            state <= st_second;
          end else if (skip_now) begin
            state <= st_skip;
          end else if (next_extra != instr_timing_pkg::EXTRA_NONE) begin
            state <= st_bubble;
          end
        end
        st_second: begin
          state <= st_fetch;
        end
        st_bubble: begin
          if (bubbles_left == instr_timing_pkg::BUBBLE_LAST) begin
            state <= st_fetch;
          end
        end
        st_skip: begin
          // a skipped two-word instruction costs one more discarded word
          if (word_class == instr_timing_pkg::cls_double) begin
            state <= st_bubble;
          end else begin
            state <= st_fetch;
          end
        end
        default: begin
          state <= st_fetch;
        end
      endcase
    end
  end

  // first word of the instruction in flight, kept for the second word
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      first_word <= instr_timing_pkg::WORD_ZERO;
    end else if (take && state == st_fetch) begin
      first_word <= word_in;
    end
  end

  // bubbles still to be discarded before the next fetch
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bubbles_left <= instr_timing_pkg::EXTRA_NONE;
    end else if (take) begin
      case (state)
        st_fetch: begin
          if (word_class != instr_timing_pkg::cls_double && !skip_now) begin
            bubbles_left <= next_extra;
          end
        end
        st_bubble: begin
          bubbles_left <= bubbles_left - 2'h1;
        end
        st_skip: begin
          if (word_class == instr_timing_pkg::cls_double) begin
            bubbles_left <= instr_timing_pkg::EXTRA_SKIP2;
          end
        end
        default: begin
          bubbles_left <= bubbles_left;
        end
      endcase
    end
  end

  // cycles spent so far on the instruction in flight
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cyc <= instr_timing_pkg::CYC_NONE;
    end else if (take) begin
      if (state == st_fetch) begin
        cyc <= instr_timing_pkg::CYC_ONE;
      end else if (state == st_bubble || state == st_skip) begin
        cyc <= cyc + 2'h1;
      end
    end
  end

  // operand fields always come from the first word of the issuing instruction
  always_comb begin
    head_word = word_in;
    if (state == st_second) begin
      head_word = first_word;
    end
    head_dest = head_word[instr_timing_pkg::DEST_HI:instr_timing_pkg::DEST_LO];
  end

  // issue of instructions to the datapath
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      issue_out <= '0;
    end else if (ce_in) begin
      issue_out.valid <= 1'b0;
      if (issue_now) begin
        issue_out.valid     <= 1'b1;
        issue_out.acc_b     <= head_word[instr_timing_pkg::ACC_SEL_BIT];
        issue_out.dest_mode <= head_dest;
        issue_out.dest_reg  <= instr_timing_pkg::DEST_REG;
        issue_out.dest_step <= (head_dest == instr_timing_pkg::DEST_POSTINC)
                               ? instr_timing_pkg::DEST_STEP : 2'h0;
        if (state == st_second) begin
          issue_out.bits <= {first_word, word_in};
        end else begin
          // a lone second word decodes as opcode zero and issues as a no-op
          issue_out.bits <= {word_in, instr_timing_pkg::WORD_ZERO};
        end
      end
    end
  end

  // bubbles: the word is dropped and nothing is issued
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bubble_out <= 1'b0;
    end else if (ce_in) begin
      bubble_out <= word_valid_in & (state == st_bubble || state == st_skip);
    end
  end

  // retirement with total cycle count
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      retire_out <= '0;
    end else if (ce_in) begin
      retire_out.done <= 1'b0;
      if (word_valid_in) begin
        case (state)
          st_fetch: begin
            if (word_class != instr_timing_pkg::cls_double && !skip_now
                && next_extra == instr_timing_pkg::EXTRA_NONE) begin
              retire_out.done   <= 1'b1;
              retire_out.cycles <= instr_timing_pkg::CYC_ONE;
            end
          end
          st_second: begin
            retire_out.done   <= 1'b1;
            retire_out.cycles <= instr_timing_pkg::CYC_TWO;
          end
          st_bubble: begin
            if (bubbles_left == instr_timing_pkg::BUBBLE_LAST) begin
              retire_out.done   <= 1'b1;
              retire_out.cycles <= cyc + 2'h1;
            end
          end
          st_skip: begin
            if (word_class != instr_timing_pkg::cls_double) begin
              retire_out.done   <= 1'b1;
              retire_out.cycles <= cyc + 2'h1;
            end
          end
          default: begin
            retire_out.done <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : instr_cycle_timing

// ===== instr_cycle_timing_props.sv
// Purpose: timing checks on the instruction cycle sequencer ports
// Assumes: one clock domain, reset_in asynchronous active high
// Notes:   class costs follow the package opcode codes
`timescale 1ns/10ps
module instr_cycle_timing_props (
  input wire logic                      clk_sys_in,
  input wire logic                      reset_in,
  input wire logic                      ce_in,
  input wire logic                      word_valid_in,
  input wire logic [23:0]               word_in,
  input wire logic                      cond_true_in,
  input wire instr_timing_pkg::issue_t  issue_out,
  input wire logic                      bubble_out,
  input wire instr_timing_pkg::retire_t retire_out
);
  logic [7:0] opc;
  assign opc = issue_out.bits[47:40];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  chk_dest_reg_13: assert property (issue_out.valid |-> issue_out.dest_reg == 4'hd)
    else $error("write-back register is not 13");
  chk_dest_step_two: assert property (issue_out.valid |->
    issue_out.dest_step == ((issue_out.dest_mode == 2'h2) ? 2'h2 : 2'h0))
    else $error("post-increment step wrong");
  chk_bubble_not_issue: assert property (bubble_out |-> !issue_out.valid)
    else $error("bubble carries an instruction");
  chk_double_two_cycles: assert property (issue_out.valid && opc inside {8'h01, 8'h02}
    |-> retire_out.done && retire_out.cycles == 2'h2) else $error("double-word not two cycles");
  chk_cond_false_one: assert property (issue_out.valid && $past(ce_in) && opc == 8'h03
    && !$past(cond_true_in) |-> retire_out.done && retire_out.cycles == 2'h1)
    else $error("false condition not one cycle");
  chk_flow_two_cycles: assert property ((issue_out.valid && opc inside {8'h04, 8'h05, 8'h06}
    && ce_in && word_valid_in) |=> bubble_out && retire_out.done && retire_out.cycles == 2'h2)
    else $error("two-cycle flow change wrong");
  chk_flow_three_cycles: assert property ((issue_out.valid
    && opc inside {8'h07, 8'h08, 8'h09} && ce_in && word_valid_in) ##1 (ce_in && word_valid_in)
    |=> bubble_out && retire_out.done && retire_out.cycles == 2'h3)
    else $error("three-cycle instruction wrong");
  chk_stall_quiet: assert property (ce_in && !word_valid_in |=> !issue_out.valid
    && !bubble_out && !retire_out.done) else $error("activity without a word");
  chk_freeze_holds: assert property (!ce_in |=> $stable(issue_out) && $stable(bubble_out)
    && $stable(retire_out)) else $error("outputs moved while frozen");
  cover property (bubble_out ##1 bubble_out);
  cover property (issue_out.valid && opc == 8'h0a);
  cover property (!ce_in ##1 ce_in);
endmodule : instr_cycle_timing_props
bind instr_cycle_timing instr_cycle_timing_props i_instr_cycle_timing_props (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in), .word_valid_in(word_valid_in),
  .word_in(word_in), .cond_true_in(cond_true_in), .issue_out(issue_out),
  .bubble_out(bubble_out), .retire_out(retire_out));

// ===== prog_mem_model.sv
// Purpose: program memory feeding three words, then going idle
// Assumes: bench loads mem before releasing reset; bit 24 is the condition driven on cond_out
// Notes:   idle bus shows the inverse of the last word, never a stale copy
`timescale 1ns/10ps
module prog_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  output logic             word_valid_out,
  output logic [23:0]      word_out,
  output logic             cond_out
);
  logic [24:0] mem [0:2];
  logic [1:0]  ptr;
  logic [23:0] last;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ptr  <= 2'h0;
      last <= 24'h000000;
    end else if (ce_in && word_valid_out) begin
      ptr  <= ptr + 2'h1;
      last <= word_out;
    end
  end
  assign word_valid_out = (ptr != 2'h3);
  assign word_out = word_valid_out ? mem[ptr][23:0] : ~last;
  assign cond_out = word_valid_out && mem[ptr][24];
endmodule : prog_mem_model

// ===== instr_cycle_timing_tb_top.sv
// Purpose: runs each opcode class through the sequencer and counts cycles
// Assumes: three-word programs, ce frozen mid-run in the awkward cases
// Notes:   counts issues, bubbles and the first retire of each run
`timescale 1ns/10ps
`define CHECK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module instr_cycle_timing_tb_top;
  typedef struct { logic [24:0] w0; logic [23:0] w1; logic [23:0] w2;
    int iss; int bub; logic [1:0] cyc; } row_t;
  row_t rows [0:13] = '{
    '{25'h0001234, 24'h000001, 24'h000002, 3, 0, 2'h1},
    '{25'h0018000, 24'h00abcd, 24'h000000, 2, 0, 2'h2},
    '{25'h0022000, 24'h001111, 24'h000000, 2, 0, 2'h2},
    '{25'h0034000, 24'h000000, 24'h000000, 3, 0, 2'h1},
    '{25'h1030000, 24'h000000, 24'h000000, 2, 1, 2'h2},
    '{25'h0040000, 24'h000000, 24'h000000, 2, 1, 2'h2},
    '{25'h0058000, 24'h000000, 24'h000000, 2, 1, 2'h2},
    '{25'h0060000, 24'h000000, 24'h000000, 2, 1, 2'h2},
    '{25'h0070000, 24'h000000, 24'h000000, 1, 2, 2'h3},
    '{25'h0080000, 24'h000000, 24'h000000, 1, 2, 2'h3},
    '{25'h0090000, 24'h000000, 24'h000000, 1, 2, 2'h3},
    '{25'h00a0000, 24'h000000, 24'h000000, 3, 0, 2'h1},
    '{25'h10a0000, 24'h000005, 24'h000000, 2, 1, 2'h2},
    '{25'h10a0000, 24'h010000, 24'h000007, 1, 2, 2'h3}};
  logic                      clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      ce = 1'b1;
  logic                      word_valid;
  logic [23:0]               word;
  logic                      cond;
  instr_timing_pkg::issue_t  issue;
  logic                      bubble;
  instr_timing_pkg::retire_t retire;
  instr_timing_pkg::issue_t  first_iss;
  logic [1:0]                first_cyc;
  logic                      got_done;
  int                        n_iss, n_bub, errors, total_checks;
  always #2 clk = ~clk;
  instr_cycle_timing i_instr_cycle_timing (.clk_sys_in(clk), .reset_in(reset), .ce_in(ce),
    .word_valid_in(word_valid), .word_in(word), .cond_true_in(cond), .issue_out(issue),
    .bubble_out(bubble), .retire_out(retire));
  prog_mem_model i_prog_mem_model (.clk_sys_in(clk), .reset_in(reset), .ce_in(ce),
    .word_valid_out(word_valid), .word_out(word), .cond_out(cond));
  // held pulses are counted once, at the edge that clears them
  always @(posedge clk) begin
    if (!reset && ce && issue.valid && n_iss == 0) first_iss = issue;
    if (!reset && ce && issue.valid) n_iss++;
    if (!reset && ce && bubble) n_bub++;
    if (!reset && ce && retire.done && !got_done) first_cyc = retire.cycles;
    if (!reset && ce && retire.done) got_done = 1'b1;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic run_row(input row_t r, input bit hold);
    logic [47:0] exp_bits;
    exp_bits = {r.w0[23:0], 24'h000000};
    if (r.w0[23:16] inside {instr_timing_pkg::OPC_DWORD, instr_timing_pkg::OPC_MOVD})
      exp_bits[23:0] = r.w1;
    reset = 1'b1;
    ce = 1'b1;
    i_prog_mem_model.mem[0] = r.w0;
    i_prog_mem_model.mem[1] = {1'b0, r.w1};
    i_prog_mem_model.mem[2] = {1'b0, r.w2};
    n_iss = 0;
    n_bub = 0;
    got_done = 1'b0;
    first_cyc = 2'h0;
    @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 ce = !(hold && i > 0 && i < 4);
    end
    `CHECK("issues", r.iss, n_iss)
    `CHECK("bubbles", r.bub, n_bub)
    `CHECK("cycles", r.cyc, first_cyc)
    `CHECK("bits", exp_bits, first_iss.bits)
    `CHECK("acc", r.w0[15], first_iss.acc_b)
    `CHECK("dest", r.w0[14:13], first_iss.dest_mode)
  endtask : run_row
  initial begin
    // run_row adds the third reset edge
    repeat (2) @(posedge clk);
    #1;
    foreach (rows[k]) run_row(rows[k], 1'b0);
    run_row(rows[1], 1'b1);
    run_row(rows[8], 1'b1);
    // reset in mid-instruction clears every output at once
    reset = 1'b1;
    @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1 `CHECK("issue", 1'b1, issue.valid)
    reset = 1'b1;
    #1 `CHECK("reset", '0, {issue, bubble, retire})
    test_done();
  end
  initial begin
    #4000;
    errors++;
    test_done();
  end
endmodule : instr_cycle_timing_tb_top
